// *** hdl/sync_timer_pkg.sv ***
// Constants for the synchronous start/stop/clear timer block.
// Assumes one 100 MHz peripheral clock and an AXI4-Lite master.
package sync_timer_pkg;
    // ==================================================
    // Register byte offsets
    localparam logic [5:0] OFS_PWM_CFG = 6'h00;
    localparam logic [5:0] OFS_SOFT_START = 6'h04;
    localparam logic [5:0] OFS_SOFT_STOP = 6'h08;
    localparam logic [5:0] OFS_TSTART_A = 6'h0C;
    localparam logic [5:0] OFS_SYNC_START = 6'h10;
    localparam logic [5:0] OFS_MT_CFG = 6'h14;
    localparam logic [5:0] OFS_PWM_CNT0 = 6'h18;
    localparam logic [5:0] OFS_PWM_CNT1 = 6'h1C;
    localparam logic [5:0] OFS_MT_CNT = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    // ==================================================
    // Fields of one channel byte in the config registers
    localparam int F_PRESC = 0;
    localparam int F_START_A = 4;
    localparam int F_STOP_A = 5;
    localparam int F_CLR_A = 6;
    localparam int CH_STRIDE = 8;
    localparam int PRESC_W = 4;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    // ==================================================
    // Widths and bus answers
    localparam int PRE_W = 16;
    localparam int PWM_CNT_W = 32;
    localparam int MT_CNT_W = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Count clock enable: prescaler low sel bits all zero
    function automatic logic count_tick(input logic [PRE_W-1:0] pre,
                                        input logic [PRESC_W-1:0] sel);
        logic [PRE_W-1:0] mask;
        mask = (PRE_W'(1) << sel) - PRE_W'(1);
        return (pre & mask) == '0;
    endfunction : count_tick

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = data[b*8 +: 8];
        end
        return res;
    endfunction : strb_merge
endpackage : sync_timer_pkg

// *** hdl/sync_timer_start_stop_clear.sv ***
// Start/stop/clear control for two PWM timer channels and two
// multi-function timer channels, with an AXI4-Lite register slave.
// Assumes ext_trigger_in_a is asynchronous to ref_clk.
// Behaviour
// - Trigger rise starts both PWM channels together when selected
// - Trigger fall stops both when selected
// - Trigger fall clears both counters when selected
// - Sync start write starts the multi timers whose bits are set
// - Start register write loads both multi timer run flags
// - CPU start/stop write beats hardware source
// - Hardware start edge sets run flag
// - Hardware stop edge clears run flag
// - Counter follows run flag at next tick
// - Events ignored until counter really starts
// - Events still accepted until counter stops
// - Start latency depends on source and clock
module sync_timer_start_stop_clear
    import sync_timer_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_b, // Async reset, low
    input wire logic ext_trigger_in_a, // External trigger pin
    input wire logic [5:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [5:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [1:0] count_run_flag, // PWM run flags
    output logic [1:0] pwm_event_en, // PWM counter really running
    output logic [PWM_CNT_W-1:0] pwm_channel_counter0, // PWM ch0 count
    output logic [PWM_CNT_W-1:0] pwm_channel_counter1, // PWM ch1 count
    output logic [1:0] mt_run, // Multi timer run flags
    output logic [MT_CNT_W-1:0] mt_counter0, // Multi timer ch0 count
    output logic [MT_CNT_W-1:0] mt_counter1 // Multi timer ch1 count
);
    // ==================================================
    // Trigger synchroniser and edge detect
    logic trg_s1_r, trg_s2_r, trg_s3_r, trg_lvl_r;
    logic trg_rise, trg_fall;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trg_s1_r <= 1'b0;
            trg_s2_r <= 1'b0;
            trg_s3_r <= 1'b0;
            trg_lvl_r <= 1'b0;
        end
        else
        begin
            trg_s1_r <= ext_trigger_in_a;
            trg_s2_r <= trg_s1_r;
            trg_s3_r <= trg_s2_r;
            if (trg_s2_r == trg_s3_r)
                trg_lvl_r <= trg_s3_r;
        end
    end

    // Level moves only once, so each edge pulses once
    assign trg_rise = trg_s2_r & trg_s3_r & ~trg_lvl_r;
    assign trg_fall = ~trg_s2_r & ~trg_s3_r & trg_lvl_r;
    // ==================================================
    // Prescaler shared by all channels
    logic [PRE_W-1:0] pre_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            pre_r <= '0;
        else
            pre_r <= pre_r + PRE_W'(1);
    end

    // ==================================================
    // AXI4-Lite write channel
    logic aw_got_r, w_got_r, bvalid_r;
    logic [5:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r;
    logic wr_fire;
    logic [1:0] wr_bits;
    logic [31:0] pwm_cfg_r, mt_cfg_r;
    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready = ~w_got_r & ~bvalid_r;
    assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
    // Command bits live in the low byte lane
    assign wr_bits = w_strb_r[0] ? w_data_r[1:0] : 2'b00;
    function automatic logic mapped(input logic [5:0] a);
        return a <= OFS_STATUS && a[1:0] == 2'b00;
    endfunction : mapped
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwm_cfg_r <= CFG_RST;
            mt_cfg_r <= CFG_RST;
        end
        else if (wr_fire && aw_addr_r == OFS_PWM_CFG)
            pwm_cfg_r <= strb_merge(pwm_cfg_r, w_data_r, w_strb_r);
        else if (wr_fire && aw_addr_r == OFS_MT_CFG)
            mt_cfg_r <= strb_merge(mt_cfg_r, w_data_r, w_strb_r);
    end
    // ==================================================
    // PWM channels: run flag, real counting, counter
    logic [1:0] sw_start, sw_stop, hw_start, hw_stop, hw_clr, tick;
    logic [1:0] run_r, act_r;
    logic [PWM_CNT_W-1:0] cnt_r [2];
    assign sw_start = (wr_fire && aw_addr_r == OFS_SOFT_START) ? wr_bits : 2'b00;
    assign sw_stop = (wr_fire && aw_addr_r == OFS_SOFT_STOP) ? wr_bits : 2'b00;
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            hw_start[i] = trg_rise & pwm_cfg_r[i*CH_STRIDE+F_START_A];
            hw_stop[i] = trg_fall & pwm_cfg_r[i*CH_STRIDE+F_STOP_A];
            hw_clr[i] = trg_fall & pwm_cfg_r[i*CH_STRIDE+F_CLR_A];
            tick[i] = count_tick(pre_r, pwm_cfg_r[i*CH_STRIDE+F_PRESC +: PRESC_W]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            run_r <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                // CPU write checked first, so it wins a collision
                if (sw_start[i])
                    run_r[i] <= 1'b1;
                else if (sw_stop[i])
                    run_r[i] <= 1'b0;
                else if (hw_start[i])
                    run_r[i] <= 1'b1;
                else if (hw_stop[i])
                    run_r[i] <= 1'b0;
            end
        end
    end

    // Latency varies with source path and prescale
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            act_r <= 2'b00;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (tick[i])
                    act_r[i] <= run_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= '{default: '0};
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (hw_clr[i])
                    cnt_r[i] <= '0;
                else if (act_r[i] && tick[i])
                    cnt_r[i] <= cnt_r[i] + PWM_CNT_W'(1);
            end
        end
    end
    assign count_run_flag = run_r;
    // Events gated by real counting, not by the run flag
    assign pwm_event_en = act_r;
    assign pwm_channel_counter0 = cnt_r[0];
    assign pwm_channel_counter1 = cnt_r[1];
    // ==================================================
    // Multi-function timer channels
    logic [1:0] mt_run_r, mt_tick;
    logic [MT_CNT_W-1:0] mt_cnt_r [2];
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            mt_tick[i] = count_tick(pre_r, mt_cfg_r[i*CH_STRIDE+F_PRESC +: PRESC_W]);
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mt_run_r <= 2'b00;
        else if (wr_fire && aw_addr_r == OFS_SYNC_START)
            mt_run_r <= mt_run_r | wr_bits;
        else if (wr_fire && aw_addr_r == OFS_TSTART_A && w_strb_r[0])
            mt_run_r <= wr_bits;
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mt_cnt_r <= '{default: '0};
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (mt_run_r[i] && mt_tick[i])
                    mt_cnt_r[i] <= mt_cnt_r[i] + MT_CNT_W'(1);
            end
        end
    end
    assign mt_run = mt_run_r;
    assign mt_counter0 = mt_cnt_r[0];
    assign mt_counter1 = mt_cnt_r[1];
    // ==================================================
    // AXI4-Lite read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_mux;
    assign s_axi_arready = ~rvalid_r;
    always_comb
    begin
        case (s_axi_araddr)
            OFS_PWM_CFG: rd_mux = pwm_cfg_r;
            OFS_SOFT_START: rd_mux = {30'h0000_0000, run_r};
            OFS_TSTART_A: rd_mux = {30'h0000_0000, mt_run_r};
            OFS_MT_CFG: rd_mux = mt_cfg_r;
            OFS_PWM_CNT0: rd_mux = cnt_r[0];
            OFS_PWM_CNT1: rd_mux = cnt_r[1];
            OFS_MT_CNT: rd_mux = {mt_cnt_r[1], mt_cnt_r[0]};
            OFS_STATUS: rd_mux = {28'h000_0000, act_r, run_r};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    // ==================================================
    // Assertions
    sequence rise_seen;
        trg_rise && !sw_start[0] && !sw_stop[0] && !sw_start[1] && !sw_stop[1];
    endsequence
    a_rise_starts_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rise_seen ##0 (pwm_cfg_r[F_START_A] && pwm_cfg_r[CH_STRIDE+F_START_A])
        |=> run_r == 2'b11)
        else $error("rise did not start both channels");
    a_fall_stops_run: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hw_stop[0] && !sw_start[0] && !sw_stop[0] && !hw_start[0] |=> !run_r[0])
        else $error("fall did not stop channel 0");
    a_fall_clears_cnt: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hw_clr[1] |=> cnt_r[1] == '0)
        else $error("fall did not clear channel 1");
    a_sync_start_mt: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_fire && aw_addr_r == OFS_SYNC_START && wr_bits == 2'b11 |=> mt_run_r == 2'b11)
        else $error("sync start missed a channel");
    a_tstart_mt: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_fire && aw_addr_r == OFS_TSTART_A && w_strb_r[0] |=> mt_run_r == $past(wr_bits))
        else $error("start register write mismatch");
    a_cpu_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sw_start[0] && hw_stop[0] |=> run_r[0])
        else $error("hardware stop beat CPU start");
    a_hw_start_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hw_start[1] && !sw_stop[1] |=> run_r[1])
        else $error("hardware start did not set flag");
    a_act_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !tick[0] |=> act_r[0] == $past(act_r[0]))
        else $error("counting changed without tick");
    a_idle_no_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !act_r[0] && !hw_clr[0] |=> cnt_r[0] == $past(cnt_r[0]))
        else $error("counter moved before really starting");
    a_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        trg_rise |=> !trg_rise [*2])
        else $error("rising edge pulsed twice");
endmodule : sync_timer_start_stop_clear

// *** sim/tb_sync_timer_start_stop_clear.sv ***
// Self-checking bench for the start/stop/clear timer block.
// Assumes the trigger source model drives the pin; the bench is the bus master.
module tb_sync_timer_start_stop_clear
    import sync_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==================================================
    // Signals and instances
    logic ref_clk, rst_b, level_cmd, slow_cmd, trig_pin;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, run, ev, mrun, r;
    logic [PWM_CNT_W-1:0] cnt0, cnt1;
    logic [MT_CNT_W-1:0] mc0, mc1;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    sync_timer_start_stop_clear sync_timer_start_stop_clear_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .ext_trigger_in_a(trig_pin),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_run_flag(run),
        .pwm_event_en(ev), .pwm_channel_counter0(cnt0), .pwm_channel_counter1(cnt1),
        .mt_run(mrun), .mt_counter0(mc0), .mt_counter1(mc1));

    trigger_source_model trigger_source_model_inst (.level_cmd(level_cmd),
        .slow_cmd(slow_cmd), .ext_trigger_in_a(trig_pin));

    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ==================================================
    // Reporting and bus tasks
    task final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task axi_write(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd))
        begin
            @(posedge ref_clk);
            if (!ad && awready === 1'h1)
            begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (!wd && wready === 1'h1)
            begin
                wd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
        // Extra edge so a following call never re-raises bready in the same step
        @(posedge ref_clk);
    endtask : axi_write

    task axi_read(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge ref_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (rvalid !== 1'h1);
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
        @(posedge ref_clk);
    endtask : axi_read

    task wait_change(input logic [1:0] from);
        int n;
        n = 0;
        while (run === from && n < 60)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_change
    // ==================================================
    // Scenarios
    task s_reset_regs();
        axi_read(OFS_PWM_CFG, d, r);
        check(d, CFG_RST);
        check(32'(run), 32'h0000_0000);
        axi_read(6'h28, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(6'h30, 32'h0000_0001, r);
        check(32'(r), 32'(RESP_SLVERR));
    endtask : s_reset_regs

    task s_pwm_sync();
        int n;
        logic [PWM_CNT_W-1:0] c;
        axi_write(OFS_PWM_CFG, 32'h0000_7373, r);
        axi_read(OFS_PWM_CFG, d, r);
        check(d, 32'h0000_7373);
        level_cmd <= 1'h1;
        wait_change(2'h0);
        check(32'(run), 32'h0000_0003);
        check(32'(ev), 32'h0000_0000);
        n = 0;
        while (ev === 2'h0 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(ev), 32'h0000_0003);
        check(32'(n >= 1 && n <= 8), 32'h0000_0001);
        check(cnt0, cnt1);
        axi_read(OFS_STATUS, d, r);
        check(d, 32'h0000_000f);
        c = cnt0;
        repeat (8) @(posedge ref_clk);
        check(cnt0, c + 32'h0000_0001);
        level_cmd <= 1'h0;
        wait_change(2'h3);
        check(32'(run), 32'h0000_0000);
        check(32'(ev), 32'h0000_0003);
        check(cnt0, 32'h0000_0000);
        check(cnt1, 32'h0000_0000);
    endtask : s_pwm_sync

    task s_stop_keep();
        logic [PWM_CNT_W-1:0] c;
        slow_cmd <= 1'h1;
        axi_write(OFS_PWM_CFG, 32'h0000_3030, r);
        level_cmd <= 1'h1;
        wait_change(2'h0);
        check(32'(run), 32'h0000_0003);
        check(32'(ev), 32'h0000_0000);
        @(posedge ref_clk);
        check(32'(ev), 32'h0000_0003);
        repeat (20) @(posedge ref_clk);
        level_cmd <= 1'h0;
        wait_change(2'h3);
        check(32'(run), 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        c = cnt0;
        repeat (5) @(posedge ref_clk);
        check(cnt0, c);
        check(cnt1, c);
        check(32'(c != '0), 32'h0000_0001);
        slow_cmd <= 1'h0;
    endtask : s_stop_keep

    task s_multi_start();
        axi_write(OFS_MT_CFG, 32'h0000_0000, r);
        axi_write(OFS_SYNC_START, 32'h0000_0003, r);
        check(32'(mrun), 32'h0000_0003);
        check(32'(mc0), 32'(mc1));
        axi_write(OFS_TSTART_A, 32'h0000_0000, r);
        check(32'(mrun), 32'h0000_0000);
        axi_write(OFS_TSTART_A, 32'h0000_0003, r);
        check(32'(mrun), 32'h0000_0003);
        check(32'(mc0), 32'(mc1));
        // Write without the low byte lane must leave the run flags alone
        wstrb <= 4'he;
        axi_write(OFS_TSTART_A, 32'h0000_0000, r);
        check(32'(mrun), 32'h0000_0003);
        wstrb <= 4'hf;
    endtask : s_multi_start

    // Sweeps the write against the stop edge; one offset must coincide
    task s_cpu_priority();
        logic dip, found;
        found = 1'h0;
        for (int k = 0; k < 8; k++)
        begin
            level_cmd <= 1'h1;
            wait_change(2'h0);
            fork
                begin
                    level_cmd <= 1'h0;
                    repeat (k) @(posedge ref_clk);
                    axi_write(OFS_SOFT_START, 32'h0000_0001, r);
                end
                begin
                    dip = 1'h0;
                    repeat (16)
                    begin
                        @(posedge ref_clk);
                        if (run[0] === 1'h0)
                            dip = 1'h1;
                    end
                end
            join
            if (!dip && run[0] === 1'h1)
                found = 1'h1;
            check(32'(run[1]), 32'h0000_0000);
            axi_write(OFS_SOFT_STOP, 32'h0000_0003, r);
        end
        check(32'(found), 32'h0000_0001);
    endtask : s_cpu_priority
    // ==================================================
    // Main sequence and hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        rst_b = 1'h0;
        level_cmd = 1'h0;
        slow_cmd = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        s_reset_regs();
        s_pwm_sync();
        s_stop_keep();
        s_multi_start();
        s_cpu_priority();
        final_report();
    end
endmodule : tb_sync_timer_start_stop_clear

// *** sim/trigger_source_model.sv ***
// Behavioural source for the external trigger pin.
// Assumes the bench changes level_cmd just after a rising edge of ref_clk.
module trigger_source_model
(
    input wire logic level_cmd, // Wanted pin level
    input wire logic slow_cmd, // Late edge when high
    output logic ext_trigger_in_a // Trigger pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial ext_trigger_in_a = 1'h0;
    // Odd delays keep pin edges away from the clock edge, as a real source would
    always @(level_cmd)
        ext_trigger_in_a <= #(slow_cmd ? 13.7 : 3.3) level_cmd;
endmodule : trigger_source_model
